//--- inc/lcfr_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef LCFR_MAP_SVH
`define LCFR_MAP_SVH

`define LCFR_ADDR_FS1 12'h090
`define LCFR_ADDR_STAT 12'h0a0
`define LCFR_ADDR_MASK 12'h0a4
`define LCFR_ADDR_CTRL 12'h0a8
`define LCFR_ADDR_STATE 12'h0ac

`define LCFR_FS1_RESET 32'h0000_0000
`define LCFR_THR_MSB 22
`define LCFR_THR_LSB 19
`define LCFR_MODE_MSB 18
`define LCFR_MODE_LSB 15
`define LCFR_DEG_MSB 14
`define LCFR_DEG_LSB 11
`define LCFR_RETRY_MSB 10
`define LCFR_RETRY_LSB 7

`define LCFR_MODE_REPORT 4'h8

`define LCFR_STAT_LOCK 0
`define LCFR_STAT_LATCH 1
`define LCFR_STAT_RETRY 2
`define LCFR_STAT_RESET 3'h0

`define LCFR_CTRL_LIMIT_MSB 3
`define LCFR_CTRL_LIMIT_LSB 0
`define LCFR_CTRL_CLEAR 8
`define LCFR_CTRL_RESET 4'h0

`define LCFR_TICK_US 50
`define LCFR_CLK_MHZ 250
`define LCFR_TICK_CYCLES (`LCFR_TICK_US * `LCFR_CLK_MHZ)

`endif

//--- inc/lcfr_pkg.sv
// Types shared by the lock current fault reaction block
package lcfr_pkg;

   typedef enum logic [3:0]
   {
      ST_RUN = 4'b0001,
      ST_RETRY = 4'b0010,
      ST_LATCH = 4'b0100,
      ST_REPORT = 4'b1000
   } lcfr_state_t;

   typedef enum logic [1:0]
   {
      ACT_HIZ = 2'h0,
      ACT_RECIRC = 2'h1,
      ACT_HS_BRAKE = 2'h2,
      ACT_LS_BRAKE = 2'h3
   } lcfr_action_t;

endpackage : lcfr_pkg

//--- verilog/lcfr_deglitch.sv
// Tick divider and over-threshold deglitch timer
`timescale 1ns/100ps
module lcfr_deglitch #(
   parameter int TICK_CYCLES = 12500
)
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Detection
   input wire logic enable,
   input wire logic over,
   input wire logic [14:0] target_ticks,
   // Results
   output logic tick,
   output logic lock_det
);

   logic [31:0] div_reg;
   logic [31:0] cnt_reg;
   logic [31:0] target_cycles;
   logic div_wrap;
   logic run;

   assign div_wrap = (div_reg == 32'(TICK_CYCLES - 1));
   assign target_cycles = 32'(target_ticks) * 32'(TICK_CYCLES);
   assign run = enable & over;

   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         div_reg <= 32'h0;
         tick <= 1'b0;
      end
      else
      begin
         div_reg <= div_wrap ? 32'h0 : div_reg + 32'h1;
         tick <= div_wrap;
      end
   end

   // Any dip below threshold restarts the timing
   always_ff @(posedge core_clk)
   begin
      if (!resetn || !run)
      begin
         cnt_reg <= 32'h0;
         lock_det <= 1'b0;
      end
      else
      begin
         if (cnt_reg != target_cycles)
            cnt_reg <= cnt_reg + 32'h1;
         lock_det <= (cnt_reg == target_cycles - 32'h1);
      end
   end

   a_det_needs_over: assert property (@(posedge core_clk) disable iff (!resetn)
      lock_det |-> $past(run) && $past(cnt_reg) == target_cycles - 32'h1)
      else $error("Lock declared without full over-threshold time");

endmodule : lcfr_deglitch

//--- verilog/lcfr_top.sv
// Lock current fault reaction with AHB-Lite register slave
// Function
// - 4-bit reaction selector, bits 18:15, reset zero
// - Code 0: latch fault, pin, tristate
// - Code 1: latch fault, pin, recirculation
// - Code 2: latch fault, pin, high-side brake
// - Code 3: latch fault, pin, low-side brake
// - Code 4: auto-retry, then latch tristated
// - Code 5: auto-retry, then latch recirculating
// - Code 6: auto-retry with high-side brake
// - Code 7: auto-retry, then latch low-side brake
// - Code 8: report on pin only
// - Codes 9 to 15 disable detection
// - 4-bit deglitch time field, bits 14:11
// - 4-bit retry wait, 100 ms to 14 s
// - Compare phase current to 0.125-8 A threshold
//
// The address map and register access over AHB-Lite were decided locally.
`timescale 1ns/100ps
`include "lcfr_map.svh"
module lcfr_top #(
   parameter int TICK_CYCLES = `LCFR_TICK_CYCLES
)
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Measured phase current in mA
   input wire logic [13:0] phase_current_ma,
   // Fault reporting
   output logic fault_indicator_pin_n,
   output logic lock_irq,
   // Power stage commands
   output logic drive_hiz,
   output logic drive_recirc,
   output logic drive_hs_brake,
   output logic drive_ls_brake
);
   import lcfr_pkg::*;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   // Threshold code to mA
   function automatic logic [13:0] thr_ma(input logic [3:0] code);
      unique case (code)
         4'h0: thr_ma = 14'd125;
         4'h1: thr_ma = 14'd250;
         4'h2: thr_ma = 14'd500;
         4'he: thr_ma = 14'd7000;
         4'hf: thr_ma = 14'd8000;
         default: thr_ma = 14'((32'(code) - 32'd1) * 32'd500);
      endcase
   endfunction : thr_ma

   // Deglitch code to 50 us ticks
   function automatic logic [14:0] deg_ticks(input logic [3:0] code);
      unique case (code)
         4'h0: deg_ticks = 15'd1;
         4'h1: deg_ticks = 15'd2;
         4'h2: deg_ticks = 15'd4;
         4'h3: deg_ticks = 15'd10;
         4'h4: deg_ticks = 15'd20;
         4'h5: deg_ticks = 15'd50;
         4'h6: deg_ticks = 15'd100;
         4'h7: deg_ticks = 15'd150;
         4'h8: deg_ticks = 15'd200;
         4'h9: deg_ticks = 15'd500;
         4'ha: deg_ticks = 15'd1000;
         4'hb: deg_ticks = 15'd1500;
         4'hc: deg_ticks = 15'd2000;
         4'hd: deg_ticks = 15'd4000;
         4'he: deg_ticks = 15'd10000;
         4'hf: deg_ticks = 15'd20000;
      endcase
   endfunction : deg_ticks

   // Retry code to 50 us ticks
   function automatic logic [18:0] retry_ticks(input logic [3:0] code);
      unique case (code)
         4'h0: retry_ticks = 19'd2000;
         4'h1: retry_ticks = 19'd10000;
         default: retry_ticks = 19'((32'(code) - 32'd1) * 32'd20000);
      endcase
   endfunction : retry_ticks

   // Bus slave
   logic pend_reg;
   logic wr_reg;
   logic [11:0] addr_reg;
   logic accept;
   logic wr_strobe;
   logic rd_strobe;
   logic [31:0] rd_mux;

   // Registers
   logic [31:0] fs1_reg;
   logic [2:0] stat_reg;
   logic [2:0] stat_next;
   logic [2:0] mask_reg;
   logic [3:0] limit_reg;
   logic wr_fs1;
   logic wr_stat;
   logic wr_mask;
   logic wr_ctrl;
   logic clear_req;

   // Reaction state
   lcfr_state_t state_reg;
   lcfr_state_t state_next;
   lcfr_action_t act_reg;
   lcfr_action_t act_next;
   logic [3:0] retry_cnt_reg;
   logic [3:0] retry_cnt_next;
   logic [18:0] wait_reg;
   logic [3:0] mode;
   logic mode_off;
   logic mode_report;
   logic mode_retry;
   logic over;
   logic detect_en;
   logic lock_raw;
   logic lock_ev;
   logic tick;
   logic wait_done;
   logic enter_latch;
   logic stage_on;

   assign accept = hsel & htrans[1] & hreadyout;
   assign wr_strobe = pend_reg & wr_reg;
   assign rd_strobe = pend_reg & ~wr_reg;
   assign wr_fs1 = wr_strobe & (addr_reg == `LCFR_ADDR_FS1);
   assign wr_stat = wr_strobe & (addr_reg == `LCFR_ADDR_STAT);
   assign wr_mask = wr_strobe & (addr_reg == `LCFR_ADDR_MASK);
   assign wr_ctrl = wr_strobe & (addr_reg == `LCFR_ADDR_CTRL);
   assign clear_req = wr_ctrl & hwdata[`LCFR_CTRL_CLEAR];

   // Unmapped reads return zero
   assign rd_mux =
      (addr_reg == `LCFR_ADDR_FS1) ? fs1_reg :
      (addr_reg == `LCFR_ADDR_STAT) ? {29'h0, stat_reg} :
      (addr_reg == `LCFR_ADDR_MASK) ? {29'h0, mask_reg} :
      (addr_reg == `LCFR_ADDR_CTRL) ? {28'h0, limit_reg} :
      (addr_reg == `LCFR_ADDR_STATE) ?
         {16'h0, retry_cnt_reg, 2'h0, act_reg, ~fault_indicator_pin_n, 3'h0, state_reg} :
      32'h0;

   // Every transfer takes one wait state, so reads see prior writes
   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         pend_reg <= 1'b0;
         wr_reg <= 1'b0;
         addr_reg <= 12'h0;
         hreadyout <= 1'b1;
         hrdata <= 32'h0;
         hresp <= 1'b0;
      end
      else
      begin
         pend_reg <= accept;
         hreadyout <= ~accept;
         if (accept)
         begin
            wr_reg <= hwrite;
            addr_reg <= haddr[11:0];
         end
         if (rd_strobe)
            hrdata <= rd_mux;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         fs1_reg <= `LCFR_FS1_RESET;
         mask_reg <= `LCFR_STAT_RESET;
         limit_reg <= `LCFR_CTRL_RESET;
      end
      else
      begin
         if (wr_fs1)
            fs1_reg <= hwdata;
         if (wr_mask)
            mask_reg <= hwdata[2:0];
         if (wr_ctrl)
            limit_reg <= hwdata[`LCFR_CTRL_LIMIT_MSB:`LCFR_CTRL_LIMIT_LSB];
      end
   end

   // Mode decode
   assign mode = fs1_reg[`LCFR_MODE_MSB:`LCFR_MODE_LSB];
   assign mode_off = mode[3] & (|mode[2:0]);
   assign mode_report = (mode == `LCFR_MODE_REPORT);
   assign mode_retry = (mode[3:2] == 2'b01);
   assign over = phase_current_ma > thr_ma(fs1_reg[`LCFR_THR_MSB:`LCFR_THR_LSB]);
   assign detect_en = ~mode_off & (state_reg == ST_RUN);
   assign lock_ev = lock_raw & detect_en;

   lcfr_deglitch #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_deglitch (
      .core_clk(core_clk),
      .resetn(resetn),
      .enable(detect_en),
      .over(over),
      .target_ticks(deg_ticks(fs1_reg[`LCFR_DEG_MSB:`LCFR_DEG_LSB])),
      .tick(tick),
      .lock_det(lock_raw)
   );

   assign wait_done = (state_reg == ST_RETRY) &
      (wait_reg == retry_ticks(fs1_reg[`LCFR_RETRY_MSB:`LCFR_RETRY_LSB]));

   // Reaction sequencing
   always_comb
   begin
      state_next = state_reg;
      act_next = act_reg;
      retry_cnt_next = retry_cnt_reg;
      unique case (state_reg)
         ST_RUN:
            if (lock_ev)
            begin
               act_next = lcfr_action_t'(mode[1:0]);
               if (mode_report)
                  state_next = ST_REPORT;
               else if (mode_retry && retry_cnt_reg < limit_reg)
                  state_next = ST_RETRY;
               else
                  state_next = ST_LATCH;
            end
         ST_RETRY:
            if (wait_done)
            begin
               state_next = ST_RUN;
               retry_cnt_next = retry_cnt_reg + 4'h1;
            end
         ST_LATCH:
            if (clear_req)
            begin
               state_next = ST_RUN;
               retry_cnt_next = 4'h0;
            end
         ST_REPORT:
            if (clear_req)
               state_next = ST_RUN;
      endcase
   end

   assign enter_latch = (state_next == ST_LATCH) & (state_reg != ST_LATCH);
   assign stage_on = (state_next == ST_RETRY) | (state_next == ST_LATCH);

   // Set wins over a same-cycle write-one clear
   assign stat_next = (stat_reg & ~(wr_stat ? hwdata[2:0] : 3'h0)) |
      {wait_done, enter_latch, lock_ev};

   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         state_reg <= ST_RUN;
         act_reg <= ACT_HIZ;
         retry_cnt_reg <= 4'h0;
         wait_reg <= 19'h0;
         stat_reg <= `LCFR_STAT_RESET;
         lock_irq <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         act_reg <= act_next;
         retry_cnt_reg <= retry_cnt_next;
         if (state_reg != ST_RETRY || wait_done)
            wait_reg <= 19'h0;
         else if (tick)
            wait_reg <= wait_reg + 19'h1;
         stat_reg <= stat_next;
         lock_irq <= |(stat_next & mask_reg);
      end
   end

   // Power stage and pin outputs
   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         fault_indicator_pin_n <= 1'b1;
         drive_hiz <= 1'b0;
         drive_recirc <= 1'b0;
         drive_hs_brake <= 1'b0;
         drive_ls_brake <= 1'b0;
      end
      else
      begin
         fault_indicator_pin_n <= (state_next == ST_RUN);
         drive_hiz <= stage_on & (act_next == ACT_HIZ);
         drive_recirc <= stage_on & (act_next == ACT_RECIRC);
         drive_hs_brake <= stage_on & (act_next == ACT_HS_BRAKE);
         drive_ls_brake <= stage_on & (act_next == ACT_LS_BRAKE);
      end
   end

   sequence s_lock_in_run(logic [3:0] code);
      lock_ev && mode == code;
   endsequence

   sequence s_latched_pin;
      state_reg == ST_LATCH && !fault_indicator_pin_n;
   endsequence

   a_latch_tristate: assert property (s_lock_in_run(4'h0) |=> s_latched_pin ##0 drive_hiz)
      else $error("Code 0 lock did not latch tristated");
   a_latch_recirc: assert property (s_lock_in_run(4'h1) |=> s_latched_pin ##0 drive_recirc)
      else $error("Code 1 lock did not latch recirculating");
   a_latch_hs_brake: assert property (s_lock_in_run(4'h2) |=> s_latched_pin ##0 drive_hs_brake)
      else $error("Code 2 lock did not latch high-side brake");
   a_latch_ls_brake: assert property (s_lock_in_run(4'h3) |=> s_latched_pin ##0 drive_ls_brake)
      else $error("Code 3 lock did not latch low-side brake");
   a_retry_entry: assert property (lock_ev && mode_retry && retry_cnt_reg < limit_reg
      |=> state_reg == ST_RETRY && !fault_indicator_pin_n)
      else $error("Retry mode lock did not start a retry");
   a_retry_exhaust: assert property (lock_ev && mode_retry && retry_cnt_reg >= limit_reg
      |=> s_latched_pin)
      else $error("Exhausted retries did not latch");
   a_retry_ends: assert property (wait_done |=> state_reg == ST_RUN &&
      retry_cnt_reg == $past(retry_cnt_reg) + 4'h1 && fault_indicator_pin_n)
      else $error("Retry wait end did not release fault");
   a_report_only: assert property (state_reg == ST_REPORT |->
      !(drive_hiz || drive_recirc || drive_hs_brake || drive_ls_brake) && !fault_indicator_pin_n)
      else $error("Report mode touched the power stage");
   a_disabled_quiet: assert property (mode_off && state_reg == ST_RUN |=>
      state_reg == ST_RUN && fault_indicator_pin_n)
      else $error("Disabled detection raised a fault");
   a_stage_matches: assert property (state_reg == ST_RETRY |->
      (act_reg == ACT_HS_BRAKE) == drive_hs_brake)
      else $error("High-side brake not held during retry");

endmodule : lcfr_top

//--- verif/lcfr_stage_model.sv
// Power stage model giving the phase current that the block measures
`timescale 1ns/100ps
module lcfr_stage_model
(
   // Clock
   input wire logic core_clk,
   // Gate commands from the block
   input wire logic drive_hiz,
   input wire logic drive_recirc,
   input wire logic drive_hs_brake,
   input wire logic drive_ls_brake,
   // Current the motor draws while driven normally
   input wire logic [13:0] demand_ma,
   // Measured phase current
   output logic [13:0] phase_current_ma
);
   logic stage_off;
   assign stage_off = drive_hiz | drive_recirc | drive_hs_brake | drive_ls_brake;
   initial phase_current_ma = 14'h0;
   // Simplified: any fault action collapses the current at once, no decay
   always @(posedge core_clk)
   begin
      phase_current_ma <= stage_off ? 14'h0 : demand_ma;
   end
endmodule : lcfr_stage_model

//--- verif/testbench.sv
// Self-checking testbench for the lock current fault reaction block
`timescale 1ns/100ps
`include "lcfr_map.svh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
   $display("BAD %s exp %h got %h", n, e, g); end end
module testbench;
   logic core_clk, resetn, hsel, hwrite, look, hreadyout, hresp, pin_n, lock_irq;
   logic rd_pend = 1'b0;
   logic d_hiz, d_rec, d_hs, d_ls;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, seed;
   logic [13:0] demand_ma, phase_current_ma;
   logic [5:0] outs;
   logic [3:0] drv;
   logic irq_e;
   logic [31:0] exp_q[$];
   string name_q[$];
   int fail_count, num_checks, cnt, thr;

   assign outs = {pin_n, lock_irq, d_hiz, d_rec, d_hs, d_ls};

   lcfr_top #(.TICK_CYCLES(4)) lcfr_top_inst (.core_clk(core_clk), .resetn(resetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .phase_current_ma(phase_current_ma), .fault_indicator_pin_n(pin_n),
      .lock_irq(lock_irq), .drive_hiz(d_hiz), .drive_recirc(d_rec),
      .drive_hs_brake(d_hs), .drive_ls_brake(d_ls));

   lcfr_stage_model lcfr_stage_model_inst (.core_clk(core_clk), .drive_hiz(d_hiz),
      .drive_recirc(d_rec), .drive_hs_brake(d_hs), .drive_ls_brake(d_ls),
      .demand_ma(demand_ma), .phase_current_ma(phase_current_ma));

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      v = v ^ (v << 5);
      return v;
   endfunction : xs

   task automatic conclude();
      if (fail_count == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : conclude

   task automatic take(input logic [31:0] got);
      string nm;
      logic [31:0] e;
      nm = name_q.pop_front();
      e = exp_q.pop_front();
      `CHK(nm, e, got)
   endtask : take

   // Checker side: takes the oldest note whenever a result shows up
   always @(posedge core_clk)
   begin
      if (rd_pend && hreadyout)
      begin
         take(hrdata);
         `CHK("hresp", 1'b0, hresp)
         rd_pend = 1'b0;
      end
      if (hsel && htrans[1] && hreadyout && !hwrite)
         rd_pend = 1'b1;
      if (look)
         take({26'h0, outs});
   end

   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {20'h0, a};
      @(posedge core_clk);
      while (hreadyout !== 1'b1) @(posedge core_clk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge core_clk);
      while (hreadyout !== 1'b1) @(posedge core_clk);
   endtask : bus

   task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
      exp_q.push_back(e);
      name_q.push_back(nm);
      bus(1'b0, a, 32'h0);
   endtask : rd

   task automatic look_outs(input logic [5:0] e, input string nm);
      exp_q.push_back({26'h0, e});
      name_q.push_back(nm);
      look <= 1'b1;
      @(posedge core_clk);
      look <= 1'b0;
      @(posedge core_clk);
   endtask : look_outs

   task automatic wait_pin(input logic lvl);
      cnt = 0;
      while (pin_n !== lvl && cnt < 12000)
      begin
         @(posedge core_clk);
         cnt++;
      end
      // A pin that never moves is a mismatch of its own
      if (pin_n !== lvl)
         fail_count++;
   endtask : wait_pin

   task automatic stall();
      seed = xs(seed);
      demand_ma <= 14'(200 + seed % 4000);
   endtask : stall

   task automatic clear_all();
      seed = xs(seed);
      demand_ma <= 14'(seed % 125);
      bus(1'b1, `LCFR_ADDR_CTRL, 32'h101);
      bus(1'b1, `LCFR_ADDR_STAT, 32'h7);
      bus(1'b1, `LCFR_ADDR_MASK, 32'h7);
      look_outs(6'b100000, "cleared");
   endtask : clear_all

   initial
   begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   // 4 retries of about 8000 cycles dominate the run
   initial
   begin
      repeat (60000) @(posedge core_clk);
      fail_count++;
      conclude();
   end

   initial
   begin
      resetn = 1'b0;
      hsel = 1'b0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      haddr = 32'h0;
      hwdata = 32'h0;
      demand_ma = 14'h0;
      look = 1'b0;
      seed = 32'h46;
      fail_count = 0;
      num_checks = 0;
      repeat (2) @(posedge core_clk);
      resetn <= 1'b1;
      @(posedge core_clk);
      rd(`LCFR_ADDR_FS1, `LCFR_FS1_RESET, "fs1_reset");
      bus(1'b1, `LCFR_ADDR_FS1, 32'hffff_ffff);
      rd(`LCFR_ADDR_FS1, 32'hffff_ffff, "fs1_rw");
      rd(12'h0f0, 32'h0, "unmapped");
      look_outs(6'b100000, "idle");
      for (int c = 0; c < 9; c++)
      begin
         irq_e = (c != 0);
         drv = (c == 8) ? 4'h0 : 4'b1000 >> (c % 4);
         bus(1'b1, `LCFR_ADDR_FS1, 32'(c) << 15);
         bus(1'b1, `LCFR_ADDR_CTRL, 32'h1);
         stall();
         wait_pin(1'b0);
         look_outs({1'b0, irq_e, drv}, "lock_outs");
         rd(`LCFR_ADDR_STATE, ((c < 4) ? 32'h4 : (c < 8) ? 32'h2 : 32'h8) | 32'h80
            | 32'((c % 4) << 8), "state_lock");
         if (c > 3 && c < 8)
         begin
            wait_pin(1'b1);
            `CHK("retry_wait", 1'b1, cnt >= 7985 && cnt <= 8010)
            look_outs({1'b1, 1'b1, 4'h0}, "retry_end");
            wait_pin(1'b0);
            look_outs({1'b0, 1'b1, drv}, "relock_outs");
            rd(`LCFR_ADDR_STATE, 32'h1084 | 32'((c % 4) << 8), "state_latch");
         end
         if (c != 8)
            rd(`LCFR_ADDR_STAT, (c > 3) ? 32'h7 : 32'h3, "status");
         clear_all();
      end
      for (int c = 9; c < 16; c++)
      begin
         bus(1'b1, `LCFR_ADDR_FS1, 32'(c) << 15);
         stall();
         repeat (20) @(posedge core_clk);
         look_outs(6'b100000, "disabled");
      end
      bus(1'b1, `LCFR_ADDR_FS1, 32'h0000_0800);
      demand_ma <= 14'd125;
      repeat (30) @(posedge core_clk);
      look_outs(6'b100000, "at_threshold");
      repeat (6)
      begin
         stall();
         repeat (5) @(posedge core_clk);
         demand_ma <= 14'h0;
         @(posedge core_clk);
      end
      look_outs(6'b100000, "short_bursts");
      stall();
      wait_pin(1'b0);
      `CHK("deglitch_time", 1'b1, cnt >= 9 && cnt <= 13)
      clear_all();
      // Threshold codes 1 to 15: equal current holds, one mA more trips
      for (int t = 1; t < 16; t++)
      begin
         thr = (t < 3) ? (125 << t) : (t < 14) ? (t - 1) * 500 : (t - 7) * 1000;
         bus(1'b1, `LCFR_ADDR_FS1, (32'(t) << `LCFR_THR_LSB) | 32'h0000_0800);
         demand_ma <= 14'(thr);
         repeat (30) @(posedge core_clk);
         look_outs(6'b100000, "thr_equal");
         demand_ma <= 14'(thr + 1);
         wait_pin(1'b0);
         look_outs(6'b011000, "thr_above");
         clear_all();
      end
      // Reset in mid-run while a fault is latched
      demand_ma <= 14'd9000;
      wait_pin(1'b0);
      demand_ma <= 14'h0;
      resetn <= 1'b0;
      repeat (2) @(posedge core_clk);
      resetn <= 1'b1;
      @(posedge core_clk);
      look_outs(6'b100000, "reset_outs");
      rd(`LCFR_ADDR_FS1, `LCFR_FS1_RESET, "fs1_rst_mid");
      rd(`LCFR_ADDR_STATE, 32'h1, "state_rst_mid");
      rd(`LCFR_ADDR_STAT, 32'h0, "stat_rst_mid");
      conclude();
   end
endmodule : testbench
